// ==== design/pism_top.sv ====
// Interrupt source map: event detection, four status groups, APB registers and the combined line.
`timescale 1ns/1ps
module pism_top
  import pism_pkg::*;
#(
  parameter int unsigned HOLD_UNIT_CYCLES = HOLD_UNIT_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  pism_pwr_state_t        power_state,
  input  wire logic              power_down_pin,
  input  wire logic              power_on_button,
  input  wire logic              reset_in_pin,
  input  wire logic              bus_supply_presence_pin,
  input  wire logic [6:0]        gpio_pin,
  input  wire logic              supply_voltage_monitor_irq,
  input  wire logic              die_overheat_irq,
  input  wire logic              output_short_detect,
  input  wire logic              first_supply_detect_irq,
  input  wire logic              watchdog_expiry_irq,
  input  wire logic              fuse_error_detect,
  input  wire logic              adc_manual_done_irq,
  input  wire logic              adc_periodic_valid,
  input  wire logic [ADC_W-1:0]  adc_periodic_result,
  output logic                   irq_line,
  output logic                   power_on_request
);

  logic [NUM_PINS-1:0] sync1_r;
  logic [NUM_PINS-1:0] pin_s_r;
  logic [NUM_PINS-1:0] pin_d_r;
  logic [NUM_PINS-1:0] pin_rise;
  logic [NUM_PINS-1:0] pin_fall;
  logic [5:0]          lvl_d_r;
  logic [5:0]          lvl_now;
  logic [5:0]          lvl_rise;
  logic [5:0]          lvl_chg;
  logic [7:0]          mask_r [4];
  logic [6:0]          rise_r;
  logic [6:0]          fall_r;
  logic [7:0]          ctrl_r;
  logic [12:0]         thr_a_r;
  logic [12:0]         thr_b_r;
  logic [5:0]          last_addr_r;
  logic [31:0]         prdata_r;
  logic [31:0]         rdata_nxt;
  logic                addr_ok;
  logic                irq_line_r;
  logic                onreq_r;
  logic                any_w;
  logic                onreq_nxt;
  logic [31:0]         hold_cnt_r;
  logic                hold_done_r;
  logic [31:0]         hold_limit;
  logic                hold_pulse;
  logic                cmp_a;
  logic                cmp_b;
  logic                is_on;
  logic [7:0]          raw_g  [4];
  logic [7:0]          clr_g  [4];
  logic [7:0]          stat_w [4];
  logic [7:0]          pend_w [4];
  logic [7:0]          line_g [4];
  logic                access;
  logic                sel_status;
  logic [1:0]          grp;
  logic                addr_new;

  // Two-stage synchroniser for all pin sources, then one more stage for edge detection.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync1_r <= '0;
      pin_s_r <= '0;
      pin_d_r <= '0;
    end else begin
      sync1_r <= {gpio_pin, bus_supply_presence_pin, reset_in_pin, power_on_button, power_down_pin};
      pin_s_r <= sync1_r;
      pin_d_r <= pin_s_r;
    end
  end

  assign pin_rise = pin_s_r & ~pin_d_r;
  assign pin_fall = ~pin_s_r & pin_d_r;

  // Internal detector levels are already on this clock; keep last value for edges.
  assign lvl_now = {fuse_error_detect, watchdog_expiry_irq, first_supply_detect_irq,
                    output_short_detect, die_overheat_irq, supply_voltage_monitor_irq};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lvl_d_r <= '0;
    end else begin
      lvl_d_r <= lvl_now;
    end
  end

  assign lvl_rise = lvl_now & ~lvl_d_r;
  assign lvl_chg  = lvl_now ^ lvl_d_r;
  assign is_on    = (power_state != PISM_OFF);

  // Long hold timer: counts while the synchronised button is low and fires once per press.
  assign hold_limit = 32'(({30'h0, ctrl_r[CTRL_HOLD_LO +: 2]} + 32'h1) * HOLD_UNIT_CYCLES);
  assign hold_pulse = !pin_s_r[PIN_BUTTON] && !hold_done_r && (hold_cnt_r == hold_limit - 32'h1);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hold_cnt_r  <= 32'h0;
      hold_done_r <= 1'b0;
    end else if (pin_s_r[PIN_BUTTON]) begin
      hold_cnt_r  <= 32'h0;
      hold_done_r <= 1'b0;
    end else if (!hold_done_r) begin
      hold_cnt_r  <= hold_cnt_r + 32'h1;
      hold_done_r <= hold_pulse;
    end
  end

  // Periodic conversion compare; the top threshold bit selects above or below.
  assign cmp_a = thr_a_r[THR_ABOVE_BIT] ? (adc_periodic_result > thr_a_r[ADC_W-1:0])
                                        : (adc_periodic_result < thr_a_r[ADC_W-1:0]);
  assign cmp_b = thr_b_r[THR_ABOVE_BIT] ? (adc_periodic_result > thr_b_r[ADC_W-1:0])
                                        : (adc_periodic_result < thr_b_r[ADC_W-1:0]);

  // Raw events placed at their group bits, before masking.
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      raw_g[g] = 8'h00;
    end
    raw_g[0][G1_SUPPLY]       = lvl_chg[0];
    raw_g[0][G1_OVERHEAT]     = lvl_chg[1] && is_on;
    raw_g[0][G1_PWR_DOWN]     = pin_rise[PIN_PWR_DOWN] || pin_fall[PIN_PWR_DOWN];
    raw_g[0][G1_LONG_HOLD]    = hold_pulse;
    raw_g[0][G1_BUTTON]       = pin_fall[PIN_BUTTON] && is_on;
    raw_g[1][G2_SHORT]        = lvl_rise[2];
    raw_g[1][G2_FIRST_SUPPLY] = lvl_rise[3] && ctrl_r[CTRL_FIRST_SEL];
    raw_g[1][G2_RESET_IN]     = pin_rise[PIN_RESET];
    raw_g[1][G2_WATCHDOG]     = lvl_rise[4];
    raw_g[1][G2_FUSE]         = lvl_rise[5];
    raw_g[2][G3_BUS_SUPPLY]   = pin_rise[PIN_BUS] || pin_fall[PIN_BUS];
    raw_g[2][G3_ADC_MANUAL]   = adc_manual_done_irq;
    raw_g[2][G3_ADC_B]        = adc_periodic_valid && cmp_b;
    raw_g[2][G3_ADC_A]        = adc_periodic_valid && cmp_a;
    raw_g[3][6:0]             = (pin_rise[PIN_GPIO +: 7] & rise_r) | (pin_fall[PIN_GPIO +: 7] & fall_r);
  end

  // Real-time line state of every source except the three converter events.
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      line_g[g] = 8'h00;
    end
    line_g[0][G1_SUPPLY]       = lvl_now[0];
    line_g[0][G1_OVERHEAT]     = lvl_now[1];
    line_g[0][G1_PWR_DOWN]     = pin_s_r[PIN_PWR_DOWN];
    line_g[0][G1_LONG_HOLD]    = hold_done_r;
    line_g[0][G1_BUTTON]       = pin_s_r[PIN_BUTTON];
    line_g[1][G2_SHORT]        = lvl_now[2];
    line_g[1][G2_FIRST_SUPPLY] = lvl_now[3];
    line_g[1][G2_RESET_IN]     = pin_s_r[PIN_RESET];
    line_g[1][G2_WATCHDOG]     = lvl_now[4];
    line_g[1][G2_FUSE]         = lvl_now[5];
    line_g[2][G3_BUS_SUPPLY]   = pin_s_r[PIN_BUS];
    line_g[3][6:0]             = pin_s_r[PIN_GPIO +: 7];
  end

  // APB decode; the slave answers in the first access cycle.
  assign access     = psel && penable;
  assign sel_status = (paddr[7:4] == OFS_STATUS[7:4]);
  assign grp        = paddr[3:2];
  assign addr_new   = (paddr[7:2] != last_addr_r);
  assign pready     = 1'b1;
  assign pslverr    = access && !addr_ok;
  assign prdata     = prdata_r;

  // Clear vectors per group; a second clear access in a row to the same register clears nothing.
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      clr_g[g] = 8'h00;
      if (access && sel_status && (grp == 2'(g)) && addr_new) begin
        if (pwrite && ctrl_r[CTRL_CLR_WRITE]) begin
          clr_g[g] = pwdata[7:0];
        end else if (!pwrite && !ctrl_r[CTRL_CLR_WRITE]) begin
          clr_g[g] = prdata_r[7:0];
        end
      end
    end
  end

  // Four status groups; masked sources are blocked before they reach the group.
  for (genvar g = 0; g < 4; g++) begin : g_bank
    pism_bank_if bif ();
    assign bif.event_v = raw_g[g] & ~mask_r[g];
    assign bif.clear_v = clr_g[g];
    assign bif.pend_en = ctrl_r[CTRL_PENDING];
    assign stat_w[g]   = bif.status;
    assign pend_w[g]   = bif.pending;
    pism_status_bank u_bank (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .bus     (bif)
    );
  end

  // Read mux, captured in the setup cycle so that read data come from a flip-flop.
  always_comb begin
    rdata_nxt = 32'h0;
    addr_ok   = 1'b1;
    case (paddr[7:4])
      OFS_STATUS[7:4]: rdata_nxt[7:0] = stat_w[grp];
      OFS_MASK[7:4]:   rdata_nxt[7:0] = mask_r[grp];
      OFS_LINE[7:4]:   rdata_nxt[7:0] = line_g[grp];
      OFS_RISE[7:4]: begin
        case (paddr[3:0])
          OFS_RISE[3:0]:  rdata_nxt[6:0]  = rise_r;
          OFS_FALL[3:0]:  rdata_nxt[6:0]  = fall_r;
          OFS_CTRL[3:0]:  rdata_nxt[7:0]  = ctrl_r;
          default:        rdata_nxt[12:0] = thr_a_r;
        endcase
      end
      OFS_THR_B[7:4]: begin
        if (paddr[3:0] == OFS_THR_B[3:0]) begin
          rdata_nxt[12:0] = thr_b_r;
        end else if (paddr[3:0] == OFS_ONREQ[3:0]) begin
          rdata_nxt[0] = onreq_r;
        end else begin
          addr_ok = 1'b0;
        end
      end
      default: addr_ok = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0) begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata_r <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= addr_ok ? rdata_nxt : 32'h0;
    end
  end

  // Last accessed register, so that back-to-back clears of one register count once.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      last_addr_r <= ADDR_RST;
    end else if (access) begin
      last_addr_r <= paddr[7:2];
    end
  end

  // Software-written configuration registers.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int g = 0; g < 4; g++) begin
        mask_r[g] <= MASK_RST;
      end
      rise_r  <= RISE_RST;
      fall_r  <= FALL_RST;
      ctrl_r  <= CTRL_RST;
      thr_a_r <= THR_RST;
      thr_b_r <= THR_RST;
    end else if (access && pwrite && addr_ok) begin
      if (paddr[7:4] == OFS_MASK[7:4]) begin
        mask_r[grp] <= pwdata[7:0];
      end
      if (paddr == OFS_RISE) begin
        rise_r <= pwdata[6:0];
      end
      if (paddr == OFS_FALL) begin
        fall_r <= pwdata[6:0];
      end
      if (paddr == OFS_CTRL) begin
        ctrl_r <= pwdata[7:0];
      end
      if (paddr == OFS_THR_A) begin
        thr_a_r <= pwdata[12:0];
      end
      if (paddr == OFS_THR_B) begin
        thr_b_r <= pwdata[12:0];
      end
    end
  end

  // Combined line and wake request from unmasked status; a button press outside the off state wakes regardless of mask.
  always_comb begin
    any_w     = 1'b0;
    onreq_nxt = stat_w[0][G1_BUTTON] || raw_g[0][G1_BUTTON];
    for (int g = 0; g < 4; g++) begin
      any_w     = any_w | (|(stat_w[g] & ~mask_r[g]));
      onreq_nxt = onreq_nxt | (|(stat_w[g] & ~mask_r[g] & ONREQ_EN[g*8 +: 8]));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_line_r <= 1'b1;
      onreq_r    <= 1'b0;
    end else begin
      irq_line_r <= ctrl_r[CTRL_POL_HIGH] ? any_w : !any_w;
      onreq_r    <= onreq_nxt;
    end
  end

  assign irq_line         = irq_line_r;
  assign power_on_request = onreq_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  supply_edge_a: assert property (lvl_chg[0] && !mask_r[0][G1_SUPPLY] |=> stat_w[0][G1_SUPPLY])
    else $error("Supply crossing not recorded.");

  overheat_off_a: assert property ((power_state == PISM_OFF) && !stat_w[0][G1_OVERHEAT] |=>
    !stat_w[0][G1_OVERHEAT]) else $error("Overheat recorded in off state.");

  pwr_down_edge_a: assert property ((pin_s_r[PIN_PWR_DOWN] != pin_d_r[PIN_PWR_DOWN]) &&
    !mask_r[0][G1_PWR_DOWN] |=> stat_w[0][G1_PWR_DOWN]) else $error("Power-down edge not recorded.");

  long_hold_a: assert property ($rose(stat_w[0][G1_LONG_HOLD]) |->
    ($past(hold_cnt_r) == $past(hold_limit) - 32'h1)) else $error("Long hold fired at wrong count.");

  button_wake_a: assert property (stat_w[0][G1_BUTTON] |=> onreq_r)
    else $error("Button press did not request power on.");

  mask_block_a: assert property (mask_r[0][G1_SUPPLY] && !stat_w[0][G1_SUPPLY] |=> !stat_w[0][G1_SUPPLY])
    else $error("Masked source was recorded.");

  line_pol_a: assert property (irq_line_r == ($past(any_w) ~^ $past(ctrl_r[CTRL_POL_HIGH])))
    else $error("Interrupt line level or polarity wrong.");

  read_clear_a: assert property (access && !pwrite && sel_status && (grp == 2'h0) && addr_new &&
    !ctrl_r[CTRL_CLR_WRITE] && (prdata_r[7:0] == stat_w[0]) && (pend_w[0] == 8'h00) &&
    ((raw_g[0] & ~mask_r[0]) == 8'h00) |=> (stat_w[0] == 8'h00)) else $error("Read did not clear group.");

  gpio_rise_a: assert property (pin_rise[PIN_GPIO] && rise_r[0] && !mask_r[3][0] |=> stat_w[3][0])
    else $error("General pin rising edge not recorded.");

endmodule : pism_top

// ==== design/pism_pkg.sv ====
// Package with register map, field positions, reset values and timing for the interrupt source map.
package pism_pkg;

  // Clock rate and the base unit of the long button hold time.
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned HOLD_UNIT_MS  = 1000;
  localparam int unsigned HOLD_UNIT_CYC = HOLD_UNIT_MS * (CLK_HZ / 1000);

  // Register byte offsets; status, mask and line state are four words each, one per group.
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_LINE   = 8'h20;
  localparam logic [7:0] OFS_RISE   = 8'h30;
  localparam logic [7:0] OFS_FALL   = 8'h34;
  localparam logic [7:0] OFS_CTRL   = 8'h38;
  localparam logic [7:0] OFS_THR_A  = 8'h3C;
  localparam logic [7:0] OFS_THR_B  = 8'h40;
  localparam logic [7:0] OFS_ONREQ  = 8'h44;

  // Bit positions inside the four status groups.
  localparam int G1_SUPPLY       = 6;
  localparam int G1_OVERHEAT     = 5;
  localparam int G1_PWR_DOWN     = 4;
  localparam int G1_LONG_HOLD    = 2;
  localparam int G1_BUTTON       = 1;
  localparam int G2_SHORT        = 6;
  localparam int G2_FIRST_SUPPLY = 5;
  localparam int G2_RESET_IN     = 4;
  localparam int G2_WATCHDOG     = 2;
  localparam int G2_FUSE         = 1;
  localparam int G3_BUS_SUPPLY   = 7;
  localparam int G3_ADC_MANUAL   = 2;
  localparam int G3_ADC_B        = 1;
  localparam int G3_ADC_A        = 0;

  // Control register fields.
  localparam int CTRL_POL_HIGH  = 0;
  localparam int CTRL_CLR_WRITE = 1;
  localparam int CTRL_PENDING   = 2;
  localparam int CTRL_FIRST_SEL = 3;
  localparam int CTRL_HOLD_LO   = 4;
  localparam int THR_ABOVE_BIT  = 12;

  // Pin positions in the synchronised pin vector.
  localparam int PIN_PWR_DOWN = 0;
  localparam int PIN_BUTTON   = 1;
  localparam int PIN_RESET    = 2;
  localparam int PIN_BUS      = 3;
  localparam int PIN_GPIO     = 4;
  localparam int NUM_PINS     = 11;
  localparam int ADC_W        = 12;

  // Reset values.
  localparam logic [7:0]  MASK_RST = 8'h00;
  localparam logic [6:0]  RISE_RST = 7'h7F;
  localparam logic [6:0]  FALL_RST = 7'h00;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [12:0] THR_RST  = 13'h0000;
  localparam logic [5:0]  ADDR_RST = 6'h3F;

  // Sources that may wake the device when unmasked, group four in the top byte.
  localparam logic [31:0] ONREQ_EN = 32'h7F876000;

  // Power state of the device as seen by the interrupt logic.
  typedef enum logic [2:0] {
    PISM_OFF    = 3'b001,
    PISM_SLEEP  = 3'b010,
    PISM_ACTIVE = 3'b100
  } pism_pwr_state_t;

endpackage : pism_pkg

// ==== design/pism_bank_if.sv ====
// Interface between the source logic and one eight-bit status group.
`timescale 1ns/1ps
interface pism_bank_if;
  logic [7:0] event_v;
  logic [7:0] clear_v;
  logic       pend_en;
  logic [7:0] status;
  logic [7:0] pending;

  modport ctrl (output event_v, output clear_v, output pend_en, input status, input pending);
  modport bank (input event_v, input clear_v, input pend_en, output status, output pending);
endinterface : pism_bank_if

// ==== design/pism_status_bank.sv ====
// One eight-bit status group with a single level of pending events per bit.
`timescale 1ns/1ps
module pism_status_bank
  import pism_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  reset_n,
  pism_bank_if.bank  bus
);

  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] pend_r;
  logic [7:0] pend_nxt;
  logic [7:0] clr_eff;

  // A clear on a bit that holds a pending event only consumes the pending copy; an event wins over a clear.
  always_comb begin
    clr_eff    = bus.clear_v & status_r;
    status_nxt = bus.event_v | (status_r & ~(clr_eff & ~pend_r));
    pend_nxt   = ({8{bus.pend_en}} & bus.event_v & ((clr_eff & pend_r) | (~clr_eff & status_r)))
               | (~clr_eff & pend_r);
  end

  // Status and pending flags.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_r <= 8'h00;
      pend_r   <= 8'h00;
    end else begin
      status_r <= status_nxt;
      pend_r   <= pend_nxt;
    end
  end

  assign bus.status  = status_r;
  assign bus.pending = pend_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  pend_store_a: assert property (bus.pend_en |=>
    ((($past(status_r) & $past(bus.event_v) & ~$past(bus.clear_v)) & ~pend_r) == 8'h00))
    else $error("Repeat event not kept as pending.");

  pend_off_a: assert property (!bus.pend_en && (pend_r == 8'h00) |=> (pend_r == 8'h00))
    else $error("Pending stored while option is off.");

endmodule : pism_status_bank

// ==== tb/pism_host_model.sv ====
// Host processor model: APB master and servicing of the combined interrupt line.
`timescale 1ns/1ps
module pism_host_model
  import pism_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        irq_line,
  input  wire logic        act_high
);
  // The bus starts idle.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer; released lines get inverted values so stale data is never reused.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer

  // Reads all four groups and repeats while the line is still asserted.
  task automatic service(output logic [31:0] seen, output int passes);
    logic [31:0] q;
    logic        e;
    seen   = 32'h0;
    passes = 0;
    do begin
      for (int g = 0; g < 4; g++) begin
        xfer(1'b0, OFS_STATUS + 8'(4 * g), 32'h0, q, e);
        seen[8*g +: 8] |= q[7:0];
      end
      passes++;
      repeat (3) @(posedge clk_sys);
    end while ((irq_line === act_high) && (passes < 4));
  endtask : service
endmodule : pism_host_model

// ==== tb/tb.sv ====
// Self-checking testbench of the interrupt source map.
`timescale 1ns/1ps
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (x)); end end
module tb;
  import pism_pkg::*;
  logic            clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, irq_line, por, act_high;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata;
  logic [18:0]     ev;
  logic [11:0]     res;
  pism_pwr_state_t pst;
  int              error_cnt, n_compared, cyc;

  pism_top #(.HOLD_UNIT_CYCLES(8)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_state(pst), .power_down_pin(ev[2]),
    .power_on_button(ev[3]), .reset_in_pin(ev[6]), .bus_supply_presence_pin(ev[9]),
    .gpio_pin(ev[18:12]), .supply_voltage_monitor_irq(ev[0]), .die_overheat_irq(ev[1]),
    .output_short_detect(ev[4]), .first_supply_detect_irq(ev[5]), .watchdog_expiry_irq(ev[7]),
    .fuse_error_detect(ev[8]), .adc_manual_done_irq(ev[10]), .adc_periodic_valid(ev[11]),
    .adc_periodic_result(res), .irq_line(irq_line), .power_on_request(por));
  pism_host_model host_u (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_line(irq_line), .act_high(act_high));

  // Clock of 25 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Toggles the chosen sources and lets the change reach status and line.
  task automatic tog(input logic [18:0] m);
    @(posedge clk_sys);
    ev <= ev ^ m;
    repeat (7) @(posedge clk_sys);
  endtask : tog
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    host_u.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host_u.xfer(1'b1, a, d, q, e);
  endtask : wr
  // Reads a status group after another word, so a clearing read is never refused.
  task automatic st(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    rd(OFS_CTRL, q);
    rd(a, q);
    `CHK(q[7:0], x)
  endtask : st
  task automatic set_state(input pism_pwr_state_t s);
    @(posedge clk_sys);
    pst <= s;
  endtask : set_state

  // Idle line, reset value of the rising enables and an unmapped address.
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    `CHK(irq_line, 1'b1)
    rd(OFS_RISE, q);
    `CHK(q, 32'h0000007F)
    host_u.xfer(1'b0, 8'h50, 32'h0, q, e);
    `CHK(e, 1'b1)
  endtask : t_reset

  // Group one: overheat ignored when off, both edges of the others, clear on read.
  task automatic t_group1();
    set_state(PISM_OFF);
    tog(19'h00002);
    tog(19'h00002);
    st(8'h00, 8'h00);
    set_state(PISM_ACTIVE);
    tog(19'h00007);
    `CHK(irq_line, 1'b0)
    `CHK(por, 1'b0)
    st(8'h00, 8'h70);
    tog(19'h00007);
    st(8'h00, 8'h70);
    st(8'h00, 8'h00);
  endtask : t_group1

  // Group two: rising edges only, wake only from short and first supply.
  task automatic t_group2();
    wr(OFS_CTRL, 32'h00000008);
    tog(19'h001C0);
    `CHK(por, 1'b0)
    tog(19'h00030);
    `CHK(por, 1'b1)
    st(8'h04, 8'h76);
    tog(19'h001F0);
    st(8'h04, 8'h00);
  endtask : t_group2

  // Group three: bus supply edges also when off, manual result and strict thresholds.
  task automatic t_group3();
    wr(OFS_THR_A, 32'h00001100);
    wr(OFS_THR_B, 32'h00000800);
    @(posedge clk_sys);
    res <= 12'h200;
    tog(19'h00200);
    tog(19'h00400);
    tog(19'h00400);
    tog(19'h00800);
    tog(19'h00800);
    st(8'h08, 8'h87);
    set_state(PISM_OFF);
    tog(19'h00200);
    st(8'h08, 8'h80);
    set_state(PISM_ACTIVE);
  endtask : t_group3

  // Group four: default rising edges, then falling edges on four of the seven pins.
  task automatic t_group4();
    tog(19'h7F000);
    st(8'h0C, 8'h7F);
    tog(19'h7F000);
    st(8'h0C, 8'h00);
    wr(OFS_FALL, 32'h00000055);
    wr(OFS_RISE, 32'h00000000);
    tog(19'h7F000);
    tog(19'h7F000);
    st(8'h0C, 8'h55);
  endtask : t_group4

  // Masked sources record nothing; a masked button press still wakes for one cycle.
  task automatic t_mask();
    wr(OFS_MASK, 32'h000000FF);
    tog(19'h00001);
    `CHK(irq_line, 1'b1)
    @(posedge clk_sys);
    ev <= ev ^ 19'h00008;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(por, 1'b1)
    repeat (4) @(posedge clk_sys);
    tog(19'h00008);
    st(8'h00, 8'h00);
    wr(OFS_MASK, 32'h00000000);
  endtask : t_mask

  // Long hold of 16 cycles against a short press.
  task automatic t_hold();
    wr(OFS_CTRL, 32'h00000010);
    tog(19'h00008);
    repeat (20) @(posedge clk_sys);
    tog(19'h00008);
    st(8'h00, 8'h06);
    tog(19'h00008);
    tog(19'h00008);
    st(8'h00, 8'h02);
  endtask : t_hold

  // Repeat events dropped or kept pending, high polarity, then clear on write.
  task automatic t_pend();
    logic [31:0] seen, q;
    int          passes;
    for (int p = 0; p < 2; p++) begin
      wr(OFS_CTRL, 32'(p * 5));
      act_high <= p[0];
      tog(19'h00080);
      tog(19'h00080);
      tog(19'h00080);
      tog(19'h00080);
      host_u.service(seen, passes);
      `CHK(seen[15:8], 8'h04)
      `CHK(passes, p + 1)
    end
    `CHK(irq_line, 1'b0)
    wr(OFS_CTRL, 32'h00000002);
    tog(19'h00090);
    rd(OFS_CTRL, q);
    wr(8'h04, 32'h00000004);
    st(8'h04, 8'h40);
    rd(OFS_CTRL, q);
    wr(8'h04, 32'h00000040);
    st(8'h04, 8'h00);
  endtask : t_pend

  // Prints the counts and the verdict and ends the run.
  task automatic wrap_up();
    $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
    if ((error_cnt == 0) && (n_compared > 0)) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // Reset for 20 cycles, then the scenarios.
  initial begin
    reset_n    = 1'b0;
    ev         = 19'h00008;
    res        = 12'h000;
    pst        = PISM_ACTIVE;
    act_high   = 1'b0;
    error_cnt  = 0;
    n_compared = 0;
    cyc        = 0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_group1();
    t_group2();
    t_group3();
    t_group4();
    t_mask();
    t_hold();
    t_pend();
    wrap_up();
  end
endmodule : tb
